// >>> src/liu_irq_pkg.sv
package liu_irq_pkg;
  localparam int CHANNELS = 2;

  // Register offsets, channel one and global; channel two sits one stride higher
  localparam logic [5:0] ADDR_TX_CFG = 6'h05;
  localparam logic [5:0] ADDR_MASK_A = 6'h13;
  localparam logic [5:0] ADDR_MASK_B = 6'h14;
  localparam logic [5:0] ADDR_EDGE_SEL = 6'h15;
  localparam logic [5:0] ADDR_STATE_A = 6'h16;
  localparam logic [5:0] ADDR_STATE_B = 6'h17;
  localparam logic [5:0] ADDR_LATCH_A = 6'h18;
  localparam logic [5:0] ADDR_LATCH_B = 6'h19;
  localparam logic [5:0] ADDR_GLOBAL = 6'h20;
  localparam logic [5:0] ADDR_CHAN_SRC = 6'h21;
  localparam logic [5:0] CHAN_STRIDE = 6'h20;

  // Field positions
  localparam int DRIVER_MONITOR_DISABLE_BIT = 5;
  localparam int GLB_MASK_BIT = 2;
  localparam int DF_BIT = 2;
  localparam int TCLK_BIT = 3;

  // Reset values and writable bits
  localparam logic [7:0] MASK_RESET = 8'h00_FF;
  localparam logic [7:0] EDGE_RESET = 8'h00_00;
  localparam logic [7:0] TX_CFG_RESET = 8'h00_00;
  localparam logic [7:0] GLOBAL_RESET = 8'h00_00;
  localparam logic [7:0] TX_CFG_WMASK = 8'h00_3F;
  localparam logic [7:0] GLOBAL_WMASK = 8'h00_DF;

  // Interrupt pin drive styles
  localparam logic [1:0] PIN_PP_LOW = 2'h1;
  localparam logic [1:0] PIN_PP_HIGH = 2'h2;

  // Timing
  localparam int SYS_CLK_NS = 100;
  localparam logic [6:0] TCLK_LOSS_MCLK_CYCLES = 7'h46;
  localparam int MCLK_TIMEOUT_NS = 2000;
  localparam int MCLK_TIMEOUT_INT = (MCLK_TIMEOUT_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;
  localparam logic [4:0] MCLK_TIMEOUT_CYC = 5'(MCLK_TIMEOUT_INT);

  typedef struct packed {
    logic equalizer_range_state;
    logic loop_activate_state;
    logic loop_deactivate_state;
    logic pattern_sync_state;
    logic alarm_ind_state;
    logic signal_loss_state;
  } line_flags_t;

  typedef struct packed {
    logic waveform_overflow_event;
    logic jitter_fifo_over_event;
    logic jitter_fifo_under_event;
    logic pattern_error_event;
    logic excess_zero_event;
    logic code_violation_event;
    logic second_timer_event;
    logic counter_overflow_event;
  } pulse_events_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [5:0] addr;
    logic [7:0] wdata;
  } reg_req_t;
endpackage

// >>> src/liu_interrupt_and_line_monitor.sv
`timescale 1ns/1ps
module liu_interrupt_and_line_monitor
  import liu_irq_pkg::*;
(
  input wire logic sys_clk,
  input wire logic resetn,
  input wire reg_req_t reg_req,
  output logic [7:0] reg_rdata,
  input wire logic mclk_pin,
  input wire logic [1:0] channel_tx_clock,
  input wire logic [1:0] drv_fault_pin,
  input wire logic [1:0] short_circuit_pin,
  input wire logic hw_mode_pin,
  input wire logic [1:0] remote_loop,
  input wire logic [1:0] pattern_on_mclk,
  input wire line_flags_t [1:0] line_flags,
  input wire pulse_events_t [1:0] pulse_events,
  input wire logic [1:0][4:0] cable_atten,
  output logic [1:0] tx_line_oe,
  output logic int_pin_out,
  output logic int_pin_oe
);

  function automatic logic [5:0] chan_addr(input logic [5:0] base, input logic ch);
    chan_addr = base + (ch ? CHAN_STRIDE : 6'h00);
  endfunction
  logic [2:0] mclk_sh;
  logic [1:0] hw_sh;
  logic mclk_edge;
  logic [4:0] mclk_gap;
  logic mclk_lost;
  logic [7:0] global_cfg;
  logic [1:0] irq_channel_flags;
  logic [1:0] pending;
  logic [1:0] tx_clock_lost;
  logic [1:0] driver_fault_state;
  logic [1:0] tclk_edge;
  logic [1:0][6:0] tclk_gap;
  logic [1:0][7:0] state_a;
  logic [1:0][7:0] set_a;
  logic [1:0][7:0] set_b;
  logic [1:0][7:0] latch_a;
  logic [1:0][7:0] latch_b;
  logic [1:0][7:0] mask_a;
  logic [1:0][7:0] mask_b;
  logic [1:0][7:0] edge_select_reg;
  logic [1:0][7:0] tx_cfg;
  logic [1:0][7:0] chan_rdata;
  logic [1:0] rd_latch_a;
  logic [1:0] new_event;
  logic irq_global_mask;
  logic irq_active;
  logic [7:0] next_rdata;
  logic next_int_out;
  logic next_int_oe;
  logic [1:0] next_line_oe;

  assign irq_global_mask = global_cfg[GLB_MASK_BIT];
  // Master clock is far slower than sys_clk, so edges are sampled
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      mclk_sh <= 3'h0;
      hw_sh <= 2'h0;
    end else begin
      mclk_sh <= {mclk_sh[1:0], mclk_pin};
      hw_sh <= {hw_sh[0], hw_mode_pin};
    end
  end

  assign mclk_edge = mclk_sh[1] & ~mclk_sh[2];

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      mclk_gap <= 5'h0;
      mclk_lost <= 1'b0;
    end else if (mclk_edge) begin
      mclk_gap <= 5'h0;
      mclk_lost <= 1'b0;
    end else if (mclk_gap >= MCLK_TIMEOUT_CYC) begin
      mclk_lost <= 1'b1;
    end else begin
      mclk_gap <= mclk_gap + 5'h1;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      global_cfg <= GLOBAL_RESET;
    end else if (reg_req.wr && reg_req.addr == ADDR_GLOBAL) begin
      global_cfg <= reg_req.wdata & GLOBAL_WMASK;
    end
  end

  genvar c;
  generate
    for (c = 0; c < CHANNELS; c++) begin : g_chan
      logic [2:0] tclk_sh;
      logic [1:0] fault_sh;
      logic [1:0] short_sh;
      logic monitor_on;
      logic [7:0] state_prev;
      logic [7:0] state_b;
      logic rd_b;
      always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
          tclk_sh <= 3'h0;
          fault_sh <= 2'h0;
          short_sh <= 2'h0;
        end else begin
          tclk_sh <= {tclk_sh[1:0], channel_tx_clock[c]};
          fault_sh <= {fault_sh[0], drv_fault_pin[c]};
          short_sh <= {short_sh[0], short_circuit_pin[c]};
        end
      end
      assign tclk_edge[c] = tclk_sh[1] ^ tclk_sh[2];
      // Gap counted in master clock edges, not sys_clk cycles
      always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
          tclk_gap[c] <= 7'h0;
          tx_clock_lost[c] <= 1'b0;
        end else if (tclk_edge[c]) begin
          tclk_gap[c] <= 7'h0;
          tx_clock_lost[c] <= 1'b0;
        end else if (mclk_edge) begin
          if (tclk_gap[c] == TCLK_LOSS_MCLK_CYCLES) begin
            tx_clock_lost[c] <= 1'b1;
          end else begin
            tclk_gap[c] <= tclk_gap[c] + 7'h1;
          end
        end
      end
      assign monitor_on = hw_sh[1] | ~tx_cfg[c][DRIVER_MONITOR_DISABLE_BIT];
      always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
          driver_fault_state[c] <= 1'b0;
        end else begin
          // Short circuit counts as driver fault
          driver_fault_state[c] <= monitor_on & (fault_sh[1] | short_sh[1]);
        end
      end
      assign state_a[c] = {line_flags[c].equalizer_range_state, line_flags[c].loop_activate_state,
                           line_flags[c].loop_deactivate_state, line_flags[c].pattern_sync_state,
                           tx_clock_lost[c], driver_fault_state[c],
                           line_flags[c].alarm_ind_state, line_flags[c].signal_loss_state};
      assign state_b = {2'h0, remote_loop[c], cable_atten[c]};
      always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
          state_prev <= 8'h00_00;
        end else begin
          state_prev <= state_a[c];
        end
      end
      assign set_a[c] = (state_a[c] ^ state_prev) & (state_a[c] | edge_select_reg[c]);
      // Direct events complete the sixteen kinds
      assign set_b[c] = pulse_events[c];
      assign rd_latch_a[c] = reg_req.rd && reg_req.addr == chan_addr(ADDR_LATCH_A, 1'(c));
      assign rd_b = reg_req.rd && reg_req.addr == chan_addr(ADDR_LATCH_B, 1'(c));
      // Per-event latch, new set beats read clear
      always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
          latch_a[c] <= 8'h00_00;
          latch_b[c] <= 8'h00_00;
        end else begin
          latch_a[c] <= (rd_latch_a[c] ? 8'h00_00 : latch_a[c]) | set_a[c];
          latch_b[c] <= (rd_b ? 8'h00_00 : latch_b[c]) | set_b[c];
        end
      end
      always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
          mask_a[c] <= MASK_RESET;
          mask_b[c] <= MASK_RESET;
          edge_select_reg[c] <= EDGE_RESET;
          tx_cfg[c] <= TX_CFG_RESET;
        end else if (reg_req.wr) begin
          if (reg_req.addr == chan_addr(ADDR_MASK_A, 1'(c))) mask_a[c] <= reg_req.wdata;
          if (reg_req.addr == chan_addr(ADDR_MASK_B, 1'(c))) mask_b[c] <= reg_req.wdata;
          if (reg_req.addr == chan_addr(ADDR_EDGE_SEL, 1'(c))) begin
            edge_select_reg[c] <= reg_req.wdata;
          end
          if (reg_req.addr == chan_addr(ADDR_TX_CFG, 1'(c))) begin
            tx_cfg[c] <= reg_req.wdata & TX_CFG_WMASK;
          end
        end
      end
      // Unmasked event latches raise the interrupt
      assign pending[c] = |(latch_a[c] & ~mask_a[c]) | |(latch_b[c] & ~mask_b[c]);
      assign new_event[c] = |(set_a[c] & ~mask_a[c]) | |(set_b[c] & ~mask_b[c]);
      // Channel source flag, set beats clear
      always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
          irq_channel_flags[c] <= 1'b0;
        end else if (new_event[c]) begin
          irq_channel_flags[c] <= 1'b1;
        end else if (rd_latch_a[c] || rd_b || !pending[c]) begin
          irq_channel_flags[c] <= 1'b0;
        end
      end
      always_comb begin
        chan_rdata[c] = 8'h00_00;
        if (reg_req.addr == chan_addr(ADDR_MASK_A, 1'(c))) chan_rdata[c] = mask_a[c];
        if (reg_req.addr == chan_addr(ADDR_MASK_B, 1'(c))) chan_rdata[c] = mask_b[c];
        if (reg_req.addr == chan_addr(ADDR_EDGE_SEL, 1'(c))) chan_rdata[c] = edge_select_reg[c];
        if (reg_req.addr == chan_addr(ADDR_TX_CFG, 1'(c))) chan_rdata[c] = tx_cfg[c];
        if (reg_req.addr == chan_addr(ADDR_STATE_A, 1'(c))) chan_rdata[c] = state_a[c];
        if (reg_req.addr == chan_addr(ADDR_STATE_B, 1'(c))) chan_rdata[c] = state_b;
        if (rd_latch_a[c]) chan_rdata[c] = latch_a[c];
        if (rd_b) chan_rdata[c] = latch_b[c];
      end
      // Loopback and master-timed patterns keep driving through transmit clock loss, not master clock loss
      assign next_line_oe[c] = !mclk_lost &&
                               !(tx_clock_lost[c] && !remote_loop[c] && !pattern_on_mclk[c]);
    end
  endgenerate

  always_comb begin
    next_rdata = chan_rdata[0] | chan_rdata[1];
    if (reg_req.addr == ADDR_GLOBAL) next_rdata = global_cfg;
    if (reg_req.addr == ADDR_CHAN_SRC) next_rdata = {6'h00, irq_channel_flags};
  end

  assign irq_active = !irq_global_mask && (|pending);

  always_comb begin
    case (global_cfg[1:0])
      PIN_PP_LOW: begin
        next_int_oe = 1'b1;
        next_int_out = !irq_active;
      end
      PIN_PP_HIGH: begin
        next_int_oe = 1'b1;
        next_int_out = irq_active;
      end
      default: begin
        next_int_oe = irq_active;
        next_int_out = 1'b0;
      end
    endcase
  end

  // Lines float during reset and drive from the first cycle after it until master clock loss, or transmit clock loss with no loopback or master-timed pattern
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      tx_line_oe <= 2'h0;
      int_pin_oe <= 1'b0;
      int_pin_out <= 1'b0;
    end else begin
      tx_line_oe <= next_line_oe;
      int_pin_oe <= next_int_oe;
      int_pin_out <= next_int_out;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      reg_rdata <= 8'h00_00;
    end else if (reg_req.rd) begin
      reg_rdata <= next_rdata;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  sequence s_read_latch_a0;
    reg_req.rd && reg_req.addr == ADDR_LATCH_A;
  endsequence
  sequence s_pp_low_held;
    global_cfg[1:0] == PIN_PP_LOW ##1 global_cfg[1:0] == PIN_PP_LOW;
  endsequence
  property p_monitor_off;
    !hw_sh[1] && tx_cfg[0][DRIVER_MONITOR_DISABLE_BIT] |=> !driver_fault_state[0];
  endproperty
  a_monitor_off: assert property (p_monitor_off) else $error("fault captured while off");
  property p_hw_forces_monitor;
    hw_sh[1] && g_chan[0].fault_sh[1] |=> driver_fault_state[0];
  endproperty
  a_hw_forces_monitor: assert property (p_hw_forces_monitor) else $error("hw mode ignored");
  property p_fault_latched;
    $rose(driver_fault_state[0]) |=> latch_a[0][DF_BIT];
  endproperty
  a_fault_latched: assert property (p_fault_latched) else $error("fault event lost");
  property p_loss_count;
    $rose(tx_clock_lost[0]) |-> $past(tclk_gap[0]) == TCLK_LOSS_MCLK_CYCLES && $past(mclk_edge);
  endproperty
  a_loss_count: assert property (p_loss_count) else $error("clock loss at wrong count");
  property p_loss_clear;
    tclk_edge[0] |=> !tx_clock_lost[0];
  endproperty
  a_loss_clear: assert property (p_loss_clear) else $error("clock loss not cleared");
  property p_loss_float;
    tx_clock_lost[0] && !remote_loop[0] && !pattern_on_mclk[0] |=> !tx_line_oe[0];
  endproperty
  a_loss_float: assert property (p_loss_float) else $error("line driven after clock loss");
  property p_mclk_float;
    mclk_lost |=> tx_line_oe == 2'h0;
  endproperty
  a_mclk_float: assert property (p_mclk_float) else $error("line driven without mclk");
  property p_pin_style;
    s_pp_low_held |-> int_pin_oe && int_pin_out == !$past(irq_active);
  endproperty
  a_pin_style: assert property (p_pin_style) else $error("push-pull drive wrong");
  property p_global_mask;
    irq_global_mask && global_cfg[1:0] == 2'h0 |=> !int_pin_oe;
  endproperty
  a_global_mask: assert property (p_global_mask) else $error("masked interrupt shown");
  property p_read_clears;
    s_read_latch_a0 ##0 set_a[0] == 8'h00_00 |=> latch_a[0] == 8'h00_00;
  endproperty
  a_read_clears: assert property (p_read_clears) else $error("latch kept after read");
  property p_flag_ack;
    s_read_latch_a0 ##0 !new_event[0] |=> !irq_channel_flags[0];
  endproperty
  a_flag_ack: assert property (p_flag_ack) else $error("channel flag kept after read");
  property p_all_clear;
    pending == 2'h0 && new_event == 2'h0 |=> irq_channel_flags == 2'h0;
  endproperty
  a_all_clear: assert property (p_all_clear) else $error("flags left with nothing pending");
  property p_rising_only;
    !edge_select_reg[0][0] && $fell(state_a[0][0]) |-> !set_a[0][0];
  endproperty
  a_rising_only: assert property (p_rising_only) else $error("falling edge latched");
  property p_irq_raise;
    pending[0] && !irq_global_mask && global_cfg[1:0] == PIN_PP_HIGH |=> int_pin_out;
  endproperty
  a_irq_raise: assert property (p_irq_raise) else $error("interrupt not raised");
endmodule

// >>> verification/liu_irq_testbench.sv
`timescale 1ns/1ps
module testbench
  import liu_irq_pkg::*;
;
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  reg_req_t reg_req = '0;
  logic [7:0] reg_rdata;
  logic mclk_pin = 1'b0;
  logic mclk_run = 1'b1;
  logic [1:0] tclk = 2'h0;
  logic [1:0] tclk_run = 2'h3;
  logic [1:0] drv_fault_pin = 2'h0;
  logic [1:0] short_pin = 2'h0;
  logic hw_mode_pin = 1'b0;
  logic [1:0] remote_loop = 2'h0;
  logic [1:0] pattern_on_mclk = 2'h0;
  line_flags_t [1:0] line_flags = '0;
  pulse_events_t [1:0] pulse_events = '0;
  logic [1:0][4:0] cable_atten = {5'h0A, 5'h15};
  logic [1:0] tx_line_oe;
  logic int_pin_out;
  logic int_pin_oe;
  int fails = 0;
  int checks_done = 0;
  int cycles = 0;
  logic [5:0] ra [12] = '{6'h05, 6'h13, 6'h14, 6'h15, 6'h16, 6'h17, 6'h18, 6'h19, 6'h20, 6'h21,
                          6'h33, 6'h3F};
  logic [7:0] rv [12] = '{8'h00, 8'hFF, 8'hFF, 8'h00, 8'h00, 8'h15, 8'h00, 8'h00, 8'h00, 8'h00,
                          8'hFF, 8'h00};

  liu_interrupt_and_line_monitor dut (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .reg_req(reg_req),
    .reg_rdata(reg_rdata),
    .mclk_pin(mclk_pin),
    .channel_tx_clock(tclk),
    .drv_fault_pin(drv_fault_pin),
    .short_circuit_pin(short_pin),
    .hw_mode_pin(hw_mode_pin),
    .remote_loop(remote_loop),
    .pattern_on_mclk(pattern_on_mclk),
    .line_flags(line_flags),
    .pulse_events(pulse_events),
    .cable_atten(cable_atten),
    .tx_line_oe(tx_line_oe),
    .int_pin_out(int_pin_out),
    .int_pin_oe(int_pin_oe)
  );

  always #50 sys_clk = ~sys_clk;
  // Free-running master clock near 2.048 MHz, unrelated to sys_clk
  always #244 if (mclk_run) mclk_pin = ~mclk_pin;
  always #300 tclk = tclk ^ tclk_run;

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 5000) begin
      fails++;
      $display("BAD %0t run took too long", $time);
      end_of_test();
    end
  end

  task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("BAD %0t register got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_pin(input logic [1:0] got, input logic [1:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("BAD %0t pins got %b expected %b", $time, got, exp);
    end
  endtask

  task automatic wait_n(input int n);
    repeat (n) @(negedge sys_clk);
  endtask

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    reg_req.wr = 1'b1;
    reg_req.addr = a;
    reg_req.wdata = d;
    @(negedge sys_clk);
    reg_req.wr = 1'b0;
  endtask

  task automatic rd_chk(input logic [5:0] a, input logic [7:0] exp);
    @(negedge sys_clk);
    reg_req.rd = 1'b1;
    reg_req.addr = a;
    @(negedge sys_clk);
    reg_req.rd = 1'b0;
    chk_reg(reg_rdata, exp);
  endtask

  // Open drain idle leaves the output value undefined, so only enable is compared
  task automatic pin_is(input logic act, input logic [1:0] style);
    logic pp;
    logic [1:0] exp;
    pp = (style == PIN_PP_LOW) || (style == PIN_PP_HIGH);
    exp = {pp | act, (style == PIN_PP_HIGH) ? act : ~act};
    if (exp[1]) chk_pin({int_pin_oe, int_pin_out}, exp);
    else chk_pin({int_pin_oe, 1'b0}, 2'h0);
  endtask

  task automatic pulse(input int ch, input int k);
    @(negedge sys_clk);
    pulse_events[ch][k] = 1'b1;
    @(negedge sys_clk);
    pulse_events[ch][k] = 1'b0;
  endtask

  // Line flag index to its bit in the state and latch registers
  function automatic int spos(input int i);
    return (i < 2) ? i : i + 2;
  endfunction

  initial begin
    wait_n(6);
    chk_pin({int_pin_oe, int_pin_out}, 2'h0);
    chk_pin(tx_line_oe, 2'h0);
    wait_n(6);
    resetn = 1'b1;
    wait_n(40);
    chk_pin(tx_line_oe, 2'h3);
    for (int r = 0; r < 12; r++) rd_chk(ra[r], rv[r]);
    wr(ADDR_MASK_A, 8'h5A);
    rd_chk(ADDR_MASK_A, 8'h5A);
    wr(ADDR_GLOBAL, 8'hFF);
    rd_chk(ADDR_GLOBAL, 8'hDF);
    wr(ADDR_GLOBAL, 8'h00);
    wr(ADDR_STATE_B, 8'hFF);
    rd_chk(ADDR_STATE_B, 8'h15);
    wr(ADDR_MASK_A, 8'h00);
    wr(ADDR_MASK_B, 8'h00);
    for (int e = 0; e < 2; e++) begin
      wr(ADDR_EDGE_SEL, e ? 8'hFF : 8'h00);
      for (int i = 0; i < 6; i++) begin
        line_flags[0][i] = 1'b1;
        wait_n(4);
        pin_is(1'b1, 2'h0);
        rd_chk(ADDR_CHAN_SRC, 8'h01);
        rd_chk(ADDR_STATE_A, 8'h01 << spos(i));
        rd_chk(ADDR_LATCH_A, 8'h01 << spos(i));
        rd_chk(ADDR_LATCH_A, 8'h00);
        rd_chk(ADDR_CHAN_SRC, 8'h00);
        line_flags[0][i] = 1'b0;
        wait_n(4);
        rd_chk(ADDR_LATCH_A, e ? (8'h01 << spos(i)) : 8'h00);
        wait_n(3);
        pin_is(1'b0, 2'h0);
      end
    end
    wr(ADDR_EDGE_SEL, 8'h00);
    for (int k = 0; k < 8; k++) begin
      pulse(0, k);
      wait_n(3);
      pin_is(1'b1, 2'h0);
      rd_chk(ADDR_LATCH_B, 8'h01 << k);
    end
    // Channel one masks only bit 0, channel two still masks all: masked events latch but stay silent
    wr(ADDR_MASK_B, 8'h01);
    pulse(0, 0);
    pulse(1, 3);
    wait_n(3);
    pin_is(1'b0, 2'h0);
    rd_chk(ADDR_CHAN_SRC, 8'h00);
    rd_chk(ADDR_LATCH_B, 8'h01);
    rd_chk(ADDR_LATCH_B + CHAN_STRIDE, 8'h08);
    wr(ADDR_GLOBAL, 8'h04);
    pulse(0, 1);
    wait_n(3);
    pin_is(1'b0, 2'h0);
    rd_chk(ADDR_LATCH_B, 8'h02);
    wr(ADDR_MASK_B + CHAN_STRIDE, 8'h00);
    for (int s = 0; s < 4; s++) begin
      wr(ADDR_GLOBAL, 8'(s));
      wait_n(3);
      pin_is(1'b0, s[1:0]);
      pulse(0, 2);
      pulse(1, 2);
      wait_n(3);
      pin_is(1'b1, s[1:0]);
      rd_chk(ADDR_CHAN_SRC, 8'h03);
      rd_chk(ADDR_LATCH_B, 8'h04);
      rd_chk(ADDR_CHAN_SRC, 8'h02);
      pin_is(1'b1, s[1:0]);
      rd_chk(ADDR_LATCH_B + CHAN_STRIDE, 8'h04);
      wait_n(3);
      pin_is(1'b0, s[1:0]);
      rd_chk(ADDR_CHAN_SRC, 8'h00);
    end
    wr(ADDR_GLOBAL, 8'h00);
    drv_fault_pin[0] = 1'b1;
    wait_n(6);
    rd_chk(ADDR_STATE_A, 8'h04);
    rd_chk(ADDR_LATCH_A, 8'h04);
    drv_fault_pin[0] = 1'b0;
    wr(ADDR_TX_CFG, 8'h20);
    drv_fault_pin[0] = 1'b1;
    wait_n(6);
    rd_chk(ADDR_STATE_A, 8'h00);
    rd_chk(ADDR_LATCH_A, 8'h00);
    hw_mode_pin = 1'b1;
    wait_n(6);
    rd_chk(ADDR_STATE_A, 8'h04);
    hw_mode_pin = 1'b0;
    drv_fault_pin[0] = 1'b0;
    wr(ADDR_TX_CFG, 8'h00);
    rd_chk(ADDR_LATCH_A, 8'h04);
    wr(ADDR_MASK_A + CHAN_STRIDE, 8'h00);
    short_pin[1] = 1'b1;
    wait_n(6);
    pin_is(1'b1, 2'h0);
    rd_chk(ADDR_LATCH_A + CHAN_STRIDE, 8'h04);
    short_pin[1] = 1'b0;
    // Channel one transmit clock stops; 70 master cycles is about 342 sys cycles
    tclk_run = 2'h2;
    wait_n(300);
    rd_chk(ADDR_STATE_A, 8'h00);
    wait_n(80);
    rd_chk(ADDR_STATE_A, 8'h08);
    chk_pin(tx_line_oe, 2'h2);
    remote_loop[0] = 1'b1;
    wait_n(3);
    chk_pin(tx_line_oe, 2'h3);
    remote_loop[0] = 1'b0;
    pattern_on_mclk[0] = 1'b1;
    wait_n(3);
    chk_pin(tx_line_oe, 2'h3);
    pattern_on_mclk[0] = 1'b0;
    rd_chk(ADDR_LATCH_A, 8'h08);
    tclk_run = 2'h3;
    wait_n(12);
    rd_chk(ADDR_STATE_A, 8'h00);
    chk_pin(tx_line_oe, 2'h3);
    mclk_run = 1'b0;
    wait_n(30);
    chk_pin(tx_line_oe, 2'h0);
    mclk_run = 1'b1;
    wait_n(40);
    chk_pin(tx_line_oe, 2'h3);
    end_of_test();
  end
endmodule
